// [include/sbr_pkg.sv]
// Constants, register map and field layout of the serial bit-rate block.
// Assumes a 32-bit APB with byte addresses; one register per aligned word.
package sbr_pkg;
	// Register byte offsets
	localparam logic [7:0] SBR_OFS_DIVISOR = 8'h00;
	localparam logic [7:0] SBR_OFS_MODE = 8'h04;
	localparam logic [7:0] SBR_OFS_FORMAT = 8'h08;
	localparam logic [7:0] SBR_OFS_STOP = 8'h0C;
	localparam logic [7:0] SBR_OFS_STATUS = 8'h10;

	// Decoded register selector
	typedef enum logic [2:0] {
		SBR_REG_DIVISOR,
		SBR_REG_MODE,
		SBR_REG_FORMAT,
		SBR_REG_STOP,
		SBR_REG_STATUS,
		SBR_REG_NONE
	} sbr_reg_t;

	// Reset values
	localparam logic [7:0] SBR_DIVISOR_RST = 8'hFF;
	localparam logic [5:0] SBR_MODE_RST = 6'h00;
	localparam logic [7:0] SBR_FORMAT_RST = 8'hF2;
	localparam logic [15:0] SBR_STOP_RST = 16'h3FFF;

	// Mode register fields
	localparam int SBR_MODE_PRE_LO = 0;
	localparam int SBR_MODE_PRE_HI = 1;
	localparam int SBR_MODE_SYNC = 2;
	localparam int SBR_MODE_CHAR7 = 3;
	localparam int SBR_MODE_EXTCLK = 4;
	localparam int SBR_MODE_CLKOUT = 5;

	// Format control fields
	localparam int SBR_FMT_CARD = 0;
	localparam int SBR_FMT_INVERT = 2;
	localparam int SBR_FMT_ORDER = 3;
	localparam logic [7:0] SBR_FMT_WMASK = 8'h0D;
	localparam logic [7:0] SBR_FMT_ONES = 8'hF2;

	// Stop control fields
	localparam int SBR_STOP_CH0 = 5;
	localparam int SBR_STOP_CH1 = 6;
	localparam int SBR_STOP_CH2 = 7;

	// Status fields
	localparam int SBR_STAT_NOCONT = 0;
	localparam int SBR_STAT_STOP_LO = 1;
	localparam int SBR_STAT_RUN = 4;

	// Prescale masks: divider input every 1, 4, 16 or 64 clocks
	localparam logic [5:0] SBR_PRE_MASK0 = 6'h00;
	localparam logic [5:0] SBR_PRE_MASK1 = 6'h03;
	localparam logic [5:0] SBR_PRE_MASK2 = 6'h0F;
	localparam logic [5:0] SBR_PRE_MASK3 = 6'h3F;

	// Index of the last sample tick of a bit in asynchronous mode; 16 ticks per bit
	localparam logic [3:0] SBR_SAMPLES_LAST = 4'hF;
endpackage : sbr_pkg

// [logic/sbr_baud_gen.sv]
// Prescaler and reloading divisor counter that produce one tick per expiry.
// Assumes the register values come from the same clock domain.
`timescale 1ns/1ps
module sbr_baud_gen
	import sbr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic [1:0] i_prescale,
	input wire logic [7:0] i_divisor,
	output logic o_tick
);
	logic [5:0] pre_cnt_q, pre_cnt_d;
	logic [7:0] div_cnt_q, div_cnt_d;
	logic tick_q, tick_d;
	logic [5:0] pre_mask;
	logic pre_en;

	// Next state of prescaler and divider
	always_comb
	begin
		case (i_prescale)
			2'b00: pre_mask = SBR_PRE_MASK0;
			2'b01: pre_mask = SBR_PRE_MASK1;
			2'b10: pre_mask = SBR_PRE_MASK2;
			default: pre_mask = SBR_PRE_MASK3;
		endcase
		pre_en = ((pre_cnt_q & pre_mask) == pre_mask);
		pre_cnt_d = pre_cnt_q + 6'h01;
		div_cnt_d = div_cnt_q;
		tick_d = 1'b0;
		if (!i_run)
		begin
			// Held at rest so a restart begins a full period
			pre_cnt_d = 6'h00;
			div_cnt_d = i_divisor;
		end
		else if (pre_en)
		begin
			if (div_cnt_q == 8'h00)
			begin
				div_cnt_d = i_divisor;
				tick_d = 1'b1;
			end
			else
				div_cnt_d = div_cnt_q - 8'h01;
		end
	end

	// Registers
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pre_cnt_q <= 6'h00;
			div_cnt_q <= SBR_DIVISOR_RST;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_cnt_q <= pre_cnt_d;
			div_cnt_q <= div_cnt_d;
			tick_q <= tick_d;
		end
	end

	assign o_tick = tick_q;
endmodule : sbr_baud_gen

// [logic/sbr_bit_order.sv]
// Registered bit-order stage: passes a byte straight or reversed.
// Assumes the caller decides when reversal is allowed.
`timescale 1ns/1ps
module sbr_bit_order
	import sbr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_reverse,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data
);
	logic [7:0] rev;
	logic [7:0] data_q, data_d;

	// Mirror the byte, bit i to bit 7-i
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : g_rev
			assign rev[g] = i_data[7 - g];
		end
	endgenerate

	// Choose order
	always_comb
	begin
		data_d = i_reverse ? rev : i_data;
	end

	// Register
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			data_q <= 8'h00;
		else
			data_q <= data_d;
	end

	assign o_data = data_q;
endmodule : sbr_bit_order

// [logic/sbr_top.sv]
// Bit-rate generator, bit-order control and channel stop control behind APB.
// Assumes standby levels come from logic on i_ref_clk; i_ext_clk is a pin.
//
// How it works
// - The 8-bit divisor N takes any value from 0 to 255 and divides the prescaled clock.
// - Prescale select 0,1,2,3 feeds the divider with the clock, /4, /16 or /64.
// - Bit rate is clock/((N+1)*2^(2n-1)*64) asynchronous, and with 8 in place of 64 synchronous.
// - Synchronous mode with prescale 0 and N 0 cannot run back to back; a flag reports it.
// - An external asynchronous clock is taken as 16 times the bit rate and skips the divider.
// - Bit-order select 0 moves data LSB first, 1 moves it MSB first, for send and receive.
// - Bit order applies only to 8-bit characters, in either mode.
// - Format control returns to F2 on reset, in standby and in module stop.
// - Format bits 7..4 and 1 read as 1 and ignore writes.
// - Writing 1 to a stop bit halts the channel after the bus cycle; 0 releases it.
// - Stop bits 7, 6, 5 belong to channels 2, 1, 0 and come out of reset set.
// - Stop control resets to 3FFF on reset and hardware standby, holds in software standby.
`timescale 1ns/1ps
module sbr_top
	import sbr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic i_ext_clk,
	input wire logic [7:0] i_transmit_holding,
	input wire logic [7:0] i_rx_shift_word,
	output logic [7:0] o_tx_shift_word,
	output logic [7:0] o_receive_holding,
	output logic o_sample_tick,
	output logic o_bit_tick,
	output logic o_sclk,
	output logic o_sclk_oe,
	output logic o_no_continuous,
	output logic [2:0] o_chan_stop
);
	// Address decode shared by read and write paths
	function automatic sbr_reg_t sbr_decode(input logic [7:0] addr);
		case (addr)
			SBR_OFS_DIVISOR: sbr_decode = SBR_REG_DIVISOR;
			SBR_OFS_MODE: sbr_decode = SBR_REG_MODE;
			SBR_OFS_FORMAT: sbr_decode = SBR_REG_FORMAT;
			SBR_OFS_STOP: sbr_decode = SBR_REG_STOP;
			SBR_OFS_STATUS: sbr_decode = SBR_REG_STATUS;
			default: sbr_decode = SBR_REG_NONE;
		endcase
	endfunction : sbr_decode

	logic [7:0] divisor_q, divisor_d;
	logic [5:0] mode_q, mode_d;
	logic [7:0] format_q, format_d;
	logic [15:0] stop_q, stop_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] status;
	logic access, wr_done;
	sbr_reg_t sel;

	// APB: one wait state, write lands on the completing edge
	always_comb
	begin
		access = i_psel & i_penable;
		sel = sbr_decode(i_paddr);
		wr_done = access & pready_q & i_pwrite;
		pready_d = access & ~pready_q;
		pslverr_d = access & ~pready_q & (sel == SBR_REG_NONE);
		prdata_d = prdata_q;
		if (access & ~pready_q & ~i_pwrite)
		begin
			case (sel)
				SBR_REG_DIVISOR: prdata_d = {24'h00_0000, divisor_q};
				SBR_REG_MODE: prdata_d = {26'h00_0000, mode_q};
				SBR_REG_FORMAT: prdata_d = {24'h00_0000, format_q | SBR_FMT_ONES};
				SBR_REG_STOP: prdata_d = {16'h0000, stop_q};
				SBR_REG_STATUS: prdata_d = status;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Register writes, with standby and module stop overrides
	always_comb
	begin
		divisor_d = divisor_q;
		mode_d = mode_q;
		format_d = format_q;
		stop_d = stop_q;
		if (wr_done)
		begin
			case (sel)
				SBR_REG_DIVISOR:
				begin
					if (i_pstrb[0])
						divisor_d = i_pwdata[7:0];
				end
				SBR_REG_MODE:
				begin
					if (i_pstrb[0])
						mode_d = i_pwdata[5:0];
				end
				SBR_REG_FORMAT:
				begin
					if (i_pstrb[0])
						format_d = (i_pwdata[7:0] & SBR_FMT_WMASK) | SBR_FMT_ONES;
				end
				SBR_REG_STOP:
				begin
					// Takes effect on the completing edge of the bus cycle
					if (i_pstrb[0])
						stop_d[7:0] = i_pwdata[7:0];
					if (i_pstrb[1])
						stop_d[15:8] = i_pwdata[15:8];
				end
				default:
				begin
					divisor_d = divisor_q;
				end
			endcase
		end
		// Software standby keeps the stop register untouched
		if (i_hw_standby)
			stop_d = SBR_STOP_RST;
		if (i_hw_standby | i_sw_standby | stop_q[SBR_STOP_CH0])
			format_d = SBR_FORMAT_RST;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			divisor_q <= SBR_DIVISOR_RST;
			mode_q <= SBR_MODE_RST;
			format_q <= SBR_FORMAT_RST;
			stop_q <= SBR_STOP_RST;
		end
		else
		begin
			divisor_q <= divisor_d;
			mode_q <= mode_d;
			format_q <= format_d;
			stop_q <= stop_d;
		end
	end

	// External clock pin: two-stage synchroniser, then edge detect on stage two
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= i_ext_clk;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	logic run, sync_mode, ext_sel, ext_rise, div_tick;
	assign sync_mode = mode_q[SBR_MODE_SYNC];
	assign ext_sel = mode_q[SBR_MODE_EXTCLK];
	assign ext_rise = ext_s2_q & ~ext_s3_q; // limits keep edges resolvable
	// Divider belongs to channel 0; it idles while stopped or on an external clock
	assign run = ~stop_q[SBR_STOP_CH0] & ~ext_sel & ~i_hw_standby & ~i_sw_standby;

	sbr_baud_gen u_baud_gen (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_run(run),
		.i_prescale({mode_q[SBR_MODE_PRE_HI], mode_q[SBR_MODE_PRE_LO]}),
		.i_divisor(divisor_q),
		.o_tick(div_tick)
	);

	// Timing: divider tick halved gives 2^(2n+1) scaling; 16 per bit async, 2 per bit sync
	logic half_q, half_d;
	logic [3:0] samp_cnt_q, samp_cnt_d;
	logic samp_tick_q, samp_tick_d;
	logic bit_tick_q, bit_tick_d;
	logic sclk_q, sclk_d;
	logic sclk_oe_q, sclk_oe_d;
	logic base_tick;
	always_comb
	begin
		half_d = run ? (half_q ^ div_tick) : 1'b0;
		base_tick = div_tick & half_q;
		samp_cnt_d = samp_cnt_q;
		samp_tick_d = 1'b0;
		bit_tick_d = 1'b0;
		sclk_d = sclk_q;
		sclk_oe_d = ~ext_sel & (sync_mode | mode_q[SBR_MODE_CLKOUT]);
		if (stop_q[SBR_STOP_CH0])
		begin
			samp_cnt_d = 4'h0;
			sclk_d = 1'b1;
		end
		else if (sync_mode)
		begin
			// Serial clock toggles each base tick, a bit completing every two; on an external clock each rise completes a bit
			if (ext_sel ? ext_rise : base_tick)
			begin
				samp_tick_d = 1'b1;
				sclk_d = ~sclk_q;
				bit_tick_d = ext_sel | sclk_q;
			end
		end
		else if (ext_sel ? ext_rise : base_tick)
		begin
			samp_tick_d = 1'b1;
			samp_cnt_d = samp_cnt_q + 4'h1;
			bit_tick_d = (samp_cnt_q == SBR_SAMPLES_LAST);
			sclk_d = samp_cnt_d[3];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			half_q <= 1'b0;
			samp_cnt_q <= 4'h0;
			samp_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
			sclk_q <= 1'b1;
			sclk_oe_q <= 1'b0;
		end
		else
		begin
			half_q <= half_d;
			samp_cnt_q <= samp_cnt_d;
			samp_tick_q <= samp_tick_d;
			bit_tick_q <= bit_tick_d;
			sclk_q <= sclk_d;
			sclk_oe_q <= sclk_oe_d;
		end
	end

	// Fastest synchronous setting cannot stream; flagged to software and the transfer logic
	logic nocont_q, nocont_d;
	logic [2:0] chan_stop_q, chan_stop_d;
	always_comb
	begin
		nocont_d = sync_mode & ~ext_sel & (mode_q[SBR_MODE_PRE_HI:SBR_MODE_PRE_LO] == 2'b00)
			& (divisor_q == 8'h00);
		chan_stop_d = {stop_q[SBR_STOP_CH2], stop_q[SBR_STOP_CH1], stop_q[SBR_STOP_CH0]};
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			nocont_q <= 1'b0;
			chan_stop_q <= 3'b111;
		end
		else
		begin
			nocont_q <= nocont_d;
			chan_stop_q <= chan_stop_d;
		end
	end

	always_comb
	begin
		status = 32'h0000_0000;
		status[SBR_STAT_NOCONT] = nocont_q;
		status[SBR_STAT_STOP_LO +: 3] = chan_stop_q;
		status[SBR_STAT_RUN] = run;
	end

	// Reversal only for 8-bit characters; card bits left to software
	logic reverse;
	assign reverse = format_q[SBR_FMT_ORDER] & ~mode_q[SBR_MODE_CHAR7];

	sbr_bit_order u_tx_order (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_reverse(reverse),
		.i_data(i_transmit_holding),
		.o_data(o_tx_shift_word)
	);

	sbr_bit_order u_rx_order (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_reverse(reverse),
		.i_data(i_rx_shift_word),
		.o_data(o_receive_holding)
	);

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_sample_tick = samp_tick_q;
	assign o_bit_tick = bit_tick_q;
	assign o_sclk = sclk_q;
	assign o_sclk_oe = sclk_oe_q;
	assign o_no_continuous = nocont_q;
	assign o_chan_stop = chan_stop_q;
endmodule : sbr_top

// [tb/sbr_assertions.sv]
// Concurrent checks on the ports of the serial bit-rate block.
// Assumes one clock domain with i_rst as its reset.
`timescale 1ns/1ps
module sbr_assertions
	import sbr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic [7:0] i_transmit_holding,
	input wire logic [7:0] o_tx_shift_word,
	input wire logic o_sample_tick,
	input wire logic [2:0] o_chan_stop
);
	logic wr_stop;
	logic [2:0] stop_exp_q;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// Last value software put into the channel stop bits; hardware standby sets them all
	assign wr_stop = i_psel && i_penable && i_pwrite && o_pready && i_paddr == SBR_OFS_STOP;
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			stop_exp_q <= 3'h7;
		else if (i_hw_standby)
			stop_exp_q <= 3'h7;
		else if (wr_stop)
			stop_exp_q <= i_pwdata[7:5];
	end
	function automatic logic [7:0] flip(input logic [7:0] v);
		return {<<{v}};
	endfunction : flip
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	property p_one_wait;
		s_setup ##1 s_access |=> o_pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late");
	property p_ready_pulse;
		o_pready |=> !o_pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	property p_err_ready;
		o_pslverr |-> o_pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_fmt_ones;
		s_access ##0 (o_pready && !i_pwrite && i_paddr == SBR_OFS_FORMAT)
			|-> o_prdata[7:4] == 4'hF && o_prdata[1];
	endproperty
	a_fmt_ones: assert property (p_fmt_ones) else $error("format fixed bits");
	property p_tx_order;
		!$past(i_rst) |-> o_tx_shift_word == $past(i_transmit_holding)
			|| o_tx_shift_word == flip($past(i_transmit_holding));
	endproperty
	a_tx_order: assert property (p_tx_order) else $error("send word order");
	property p_stop_write;
		wr_stop |-> ##[1:2] o_chan_stop == stop_exp_q;
	endproperty
	a_stop_write: assert property (p_stop_write) else $error("stop bits");
	property p_hw_standby;
		i_hw_standby |-> ##[1:2] o_chan_stop == 3'h7;
	endproperty
	a_hw_standby: assert property (p_hw_standby) else $error("hw standby stop");
	property p_sw_keep;
		(i_sw_standby && !i_hw_standby && !i_psel) [*3] |-> $stable(o_chan_stop);
	endproperty
	a_sw_keep: assert property (p_sw_keep) else $error("sw standby stop");
	property p_stop_quiet;
		(o_chan_stop[0]) [*3] |-> !o_sample_tick;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("tick while stopped");
endmodule : sbr_assertions

bind sbr_top sbr_assertions sbr_assertions_inst (.i_ref_clk, .i_rst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_hw_standby,
	.i_sw_standby, .i_transmit_holding, .o_tx_shift_word, .o_sample_tick, .o_chan_stop);

// [tb/sbr_ext_clk_src.sv]
// External clock source that drives the serial clock pin.
// Assumes the bench sets the half period; zero keeps the pin still and low.
`timescale 1ns/1ps
module sbr_ext_clk_src
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_half,
	output logic o_ext_clk
);
	logic [3:0] cnt_q;
	// Half period 2 is a quarter, 3 a sixth of the clock; never faster
	always @(posedge i_ref_clk)
	begin
		if (i_rst || i_half == 4'h0)
		begin
			cnt_q <= 4'h1;
			o_ext_clk <= 1'h0;
		end
		else if (cnt_q >= i_half)
		begin
			cnt_q <= 4'h1;
			o_ext_clk <= ~o_ext_clk;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : sbr_ext_clk_src

// [tb/tb.sv]
// Self-checking bench for the serial bit-rate block behind APB.
// Assumes a 50 MHz clock and the external clock model on the pin.
`timescale 1ns/1ps
module tb
	import sbr_pkg::*;
;
	typedef struct {logic [5:0] mode; logic [7:0] div; logic [3:0] half;
		int per; logic nc;} sbr_tb_row_t;
	logic i_ref_clk = 1'h0;
	logic i_rst = 1'h1;
	logic i_psel = 1'h0;
	logic i_penable = 1'h0;
	logic i_pwrite = 1'h0;
	logic i_hw_standby = 1'h0;
	logic i_sw_standby = 1'h0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [3:0] i_pstrb = 4'hF;
	logic [3:0] half = 4'h0;
	logic [7:0] i_transmit_holding = 8'h01;
	logic [7:0] i_rx_shift_word = 8'h02;
	logic [31:0] o_prdata, q;
	logic [7:0] o_tx_shift_word, o_receive_holding;
	logic [2:0] o_chan_stop;
	logic o_pready, o_pslverr, o_sample_tick, o_bit_tick, o_sclk, o_sclk_oe, o_no_continuous;
	logic e, i_ext_clk;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int p;
	// Mode, divisor, external half period, clocks per bit, no-continuous flag
	sbr_tb_row_t rows [8] = '{'{6'h04, 8'h00, 4'h0, 4, 1'h1},
		'{6'h05, 8'h02, 4'h0, 48, 1'h0},
		'{6'h04, 8'hFF, 4'h0, 1024, 1'h0},
		'{6'h00, 8'h00, 4'h0, 32, 1'h0},
		'{6'h02, 8'h01, 4'h0, 1024, 1'h0},
		'{6'h03, 8'h00, 4'h0, 2048, 1'h0},
		'{6'h10, 8'h05, 4'h2, 64, 1'h0},
		'{6'h14, 8'h00, 4'h3, 6, 1'h0}};
	sbr_top sbr_top_inst (.i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_hw_standby, .i_sw_standby,
		.i_ext_clk, .i_transmit_holding, .i_rx_shift_word, .o_tx_shift_word,
		.o_receive_holding, .o_sample_tick, .o_bit_tick, .o_sclk, .o_sclk_oe,
		.o_no_continuous, .o_chan_stop);
	sbr_ext_clk_src sbr_ext_clk_src_inst (.i_ref_clk, .i_rst, .i_half(half), .o_ext_clk(i_ext_clk));
	always #10 i_ref_clk = ~i_ref_clk;
	task results;
		$display("checks %0d, fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	task chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x)
		begin
			fails++;
			$display("CHECK FAILED %0t: got %h, expected %h", $time, g, x);
		end
	endtask : chk
	// One APB transfer; the request stands until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'h1;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (o_pready !== 1'h1 && n < 20);
		q = o_prdata;
		e = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		chk(n < 20, 1'h1);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0000_0000);
		chk(q, x);
	endtask : rd
	task w3;
		repeat (3) @(posedge i_ref_clk);
	endtask : w3
	// Clocks from the call to the next bit tick
	task gap(output int n);
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (o_bit_tick !== 1'h1 && n < 5000);
	endtask : gap
	// Hang guard, well above the longest expected run
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			results();
		end
	end
	initial
	begin
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		wr(SBR_OFS_STOP, 32'h0000_0000);
		foreach (rows[i])
		begin
			half <= rows[i].half;
			wr(SBR_OFS_MODE, 32'(rows[i].mode));
			wr(SBR_OFS_DIVISOR, 32'(rows[i].div));
			repeat (3) gap(p);
			chk(p, rows[i].per);
			chk(o_no_continuous, rows[i].nc);
		end
		half <= 4'h0;
		// Second reset in mid-run, then reset values and an unmapped address
		i_rst <= 1'h1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		rd(SBR_OFS_DIVISOR, 32'h0000_00FF);
		rd(SBR_OFS_MODE, 32'h0000_0000);
		rd(SBR_OFS_FORMAT, 32'h0000_00F2);
		rd(SBR_OFS_STOP, 32'h0000_3FFF);
		chk(o_chan_stop, 3'h7);
		rd(8'h14, 32'h0000_0000);
		chk(e, 1'h1);
		wr(SBR_OFS_STOP, 32'h0000_0040);
		w3();
		chk(o_chan_stop, 3'h2);
		wr(SBR_OFS_FORMAT, 32'h0000_0000);
		rd(SBR_OFS_FORMAT, 32'h0000_00F2);
		wr(SBR_OFS_FORMAT, 32'h0000_000D);
		rd(SBR_OFS_FORMAT, 32'h0000_00FF);
		wr(SBR_OFS_FORMAT, 32'h0000_0008);
		w3();
		chk(o_tx_shift_word, 8'h80);
		chk(o_receive_holding, 8'h40);
		wr(SBR_OFS_MODE, 32'h0000_0008);
		w3();
		chk(o_tx_shift_word, 8'h01);
		// Fastest synchronous clock: serial clock driven, low for two clocks after a bit tick
		wr(SBR_OFS_MODE, 32'h0000_0004);
		wr(SBR_OFS_DIVISOR, 32'h0000_0000);
		gap(p);
		chk(o_sclk_oe, 1'h1);
		chk(o_sclk, 1'h0);
		repeat (2) @(posedge i_ref_clk);
		chk(o_sclk, 1'h1);
		wr(SBR_OFS_MODE, 32'h0000_0000);
		w3();
		chk(o_sclk_oe, 1'h0);
		// Module stop: no ticks, format held at its reset value
		wr(SBR_OFS_STOP, 32'h0000_0020);
		w3();
		chk(o_chan_stop, 3'h1);
		chk(o_sclk, 1'h1);
		rd(SBR_OFS_FORMAT, 32'h0000_00F2);
		p = 0;
		repeat (50)
		begin
			@(posedge i_ref_clk);
			if (o_sample_tick !== 1'h0)
				p++;
		end
		chk(p, 0);
		wr(SBR_OFS_STOP, 32'h0000_0000);
		wr(SBR_OFS_FORMAT, 32'h0000_0008);
		i_sw_standby <= 1'h1;
		w3();
		rd(SBR_OFS_STOP, 32'h0000_0000);
		rd(SBR_OFS_FORMAT, 32'h0000_00F2);
		i_sw_standby <= 1'h0;
		i_hw_standby <= 1'h1;
		w3();
		i_hw_standby <= 1'h0;
		rd(SBR_OFS_STOP, 32'h0000_3FFF);
		results();
	end
endmodule : tb
